//--- include/swc_pkg.sv
// Package: timing constants, CRC polynomial and states for the single-wire slave
// Notes on behaviour
// - Every CRC is eight bits with polynomial x^8 + x^5 + x^4 + 1.
// - Identity code top byte is a CRC over its first 56 bits.
// - Write commands: device returns CRC over command, address and data.
// - Read commands: device returns CRC over command and address bytes.
// - Read-with-CRC: device gives CRC per page and over status bytes.
// - Device never stops or alters a sequence on CRC mismatch.
// - Read bit valid within 1 us of the fall, held at least 14 us.
// - After reset rise, device waits 15-60 us then pulls low 60-240 us.
// - Read zero: device pulls line low; read one: line left alone.
// - Line low beyond 120 us is taken as a reset.
package swc_pkg;
   localparam int CLK_NS = 100;
   localparam int RESET_DETECT_US = 120;
   localparam int PRESENCE_WAIT_US = 30;
   localparam int PRESENCE_PULSE_US = 120;
   localparam int SAMPLE_POINT_US = 30;
   localparam int READ_HOLD_US = 30;
   localparam int RESET_DETECT_CYC = (RESET_DETECT_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int PRESENCE_WAIT_CYC = (PRESENCE_WAIT_US * 1000) / CLK_NS;
   localparam int PRESENCE_PULSE_CYC = (PRESENCE_PULSE_US * 1000) / CLK_NS;
   localparam int SAMPLE_POINT_CYC = (SAMPLE_POINT_US * 1000) / CLK_NS;
   localparam int READ_HOLD_CYC = (READ_HOLD_US * 1000) / CLK_NS;
   localparam int CNT_W = 12;
   localparam logic [7:0] CRC_POLY_REV = 8'h8c;
   localparam logic [7:0] CRC_RESET = 8'h00;
   typedef enum logic [2:0] {
      SWC_IDLE = 3'b000,
      SWC_LOW = 3'b001,
      SWC_PWAIT = 3'b011,
      SWC_PRES = 3'b010,
      SWC_SLOT = 3'b110,
      SWC_WAITHI = 3'b111
   } swc_state_t;
   function automatic logic [7:0] crc_step(input logic [7:0] crc, input logic bit_in);
      logic fb;
      fb = crc[0] ^ bit_in;
      crc_step = {1'b0, crc[7:1]} ^ (fb ? CRC_POLY_REV : 8'h00);
   endfunction
endpackage

//--- include/swc_crc_if.sv
// Interface: bit stream into the CRC engine
`timescale 1ns/1ns
interface swc_crc_if;
   logic clear;
   logic shift;
   logic bit_in;
   logic [7:0] crc;
   modport link (output clear, output shift, output bit_in, input crc);
   modport engine (input clear, input shift, input bit_in, output crc);
endinterface

//--- core/swc_crc.sv
// CRC-8 engine fed one bit at a time
`timescale 1ns/1ns
module swc_crc (
   input wire logic clk,
   input wire logic rst_n,
   swc_crc_if.engine crc_bus
);
   // ************************************
   // Shift register
   // ************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         crc_bus.crc <= swc_pkg::CRC_RESET;
      end else if (crc_bus.clear) begin
         crc_bus.crc <= swc_pkg::CRC_RESET;
      end else if (crc_bus.shift) begin
         crc_bus.crc <= swc_pkg::crc_step(crc_bus.crc, crc_bus.bit_in);
      end
   end

   a_crc_clear: assert property (@(posedge clk) disable iff (!rst_n)
      crc_bus.clear |=> crc_bus.crc == 8'h00)
      else $error("crc not cleared");
endmodule // swc_crc

//--- core/swc_slave.sv
// Single-wire slave: reset/presence, time slots, CRC over the bit stream
`timescale 1ns/1ns
module swc_slave (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic dq_in,
   output logic dq_out,
   output logic dq_oe,
   input wire logic tx_bit,
   input wire logic tx_mode,
   input wire logic crc_clear,
   input wire logic crc_send,
   output logic rx_bit,
   output logic rx_valid,
   output logic bus_reset,
   output logic [7:0] crc_value
);
   // ************************************
   // Pin synchroniser
   // ************************************
   logic [2:0] sync;
   logic line;
   logic fall;
   logic rise;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync <= 3'h7;
      end else begin
         sync <= {sync[1:0], dq_in};
      end
   end
   // line holds the last level on which stages two and three agreed; first stage feeds only the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         line <= 1'b1;
      end else if (sync[1] == sync[2]) begin
         line <= sync[2];
      end
   end
   assign fall = line && (sync[1] == sync[2]) && !sync[2];
   assign rise = !line && (sync[1] == sync[2]) && sync[2];

   // ************************************
   // CRC engine
   // ************************************
   swc_crc_if crc_bus ();
   swc_crc u_crc (
      .clk(clk),
      .rst_n(rst_n),
      .crc_bus(crc_bus)
   );

   // ************************************
   // Slot state machine
   // ************************************
   swc_pkg::swc_state_t state;
   logic [swc_pkg::CNT_W-1:0] cnt;
   logic [swc_pkg::CNT_W-1:0] low_cnt;
   logic drive_zero;
   logic [7:0] send_crc;
   logic [2:0] send_idx;
   logic cur_tx;
   assign cur_tx = crc_send ? send_crc[send_idx] : tx_bit;

   // Low-time watchdog counts in every state; only SLOT and WAITHI act on it to reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         low_cnt <= '0;
      end else if (line || drive_zero) begin
         // Own pull never counts: a 120 us presence would otherwise look like a reset
         low_cnt <= '0;
      end else if (low_cnt != swc_pkg::CNT_W'(swc_pkg::RESET_DETECT_CYC)) begin
         low_cnt <= low_cnt + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= swc_pkg::SWC_IDLE;
         cnt <= '0;
         drive_zero <= 1'b0;
         rx_bit <= 1'b0;
         rx_valid <= 1'b0;
         bus_reset <= 1'b0;
      end else begin
         rx_valid <= 1'b0;
         bus_reset <= 1'b0;
         cnt <= cnt + 1'b1;
         unique case (state)
            swc_pkg::SWC_IDLE: begin
               if (fall) begin
                  cnt <= '0;
                  state <= swc_pkg::SWC_SLOT;
                  drive_zero <= tx_mode && !cur_tx;
               end
            end
            swc_pkg::SWC_SLOT: begin
               if (low_cnt == swc_pkg::CNT_W'(swc_pkg::RESET_DETECT_CYC)) begin
                  drive_zero <= 1'b0;
                  state <= swc_pkg::SWC_LOW;
               end else if (cnt == swc_pkg::CNT_W'(swc_pkg::SAMPLE_POINT_CYC)) begin
                  if (!tx_mode) begin
                     rx_bit <= line;
                     rx_valid <= 1'b1;
                  end
               end else if (cnt == swc_pkg::CNT_W'(swc_pkg::READ_HOLD_CYC + 1)) begin
                  drive_zero <= 1'b0;
                  state <= swc_pkg::SWC_WAITHI;
               end
            end
            swc_pkg::SWC_WAITHI: begin
               if (low_cnt == swc_pkg::CNT_W'(swc_pkg::RESET_DETECT_CYC)) begin
                  state <= swc_pkg::SWC_LOW;
               end else if (line) begin
                  state <= swc_pkg::SWC_IDLE;
               end
            end
            swc_pkg::SWC_LOW: begin
               if (rise) begin
                  cnt <= '0;
                  bus_reset <= 1'b1;
                  state <= swc_pkg::SWC_PWAIT;
               end
            end
            swc_pkg::SWC_PWAIT: begin
               if (cnt == swc_pkg::CNT_W'(swc_pkg::PRESENCE_WAIT_CYC)) begin
                  cnt <= '0;
                  drive_zero <= 1'b1;
                  state <= swc_pkg::SWC_PRES;
               end
            end
            swc_pkg::SWC_PRES: begin
               if (cnt == swc_pkg::CNT_W'(swc_pkg::PRESENCE_PULSE_CYC - 1)) begin
                  drive_zero <= 1'b0;
                  state <= swc_pkg::SWC_WAITHI;
               end
            end
            default: state <= swc_pkg::SWC_IDLE;
         endcase
      end
   end

   // ************************************
   // CRC feed; result goes out regardless of any mismatch
   // ************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         send_crc <= 8'h00;
         send_idx <= 3'h0;
      end else if (!crc_send) begin
         send_crc <= crc_bus.crc;
         send_idx <= 3'h0;
      end else if (state == swc_pkg::SWC_IDLE && fall) begin
         send_idx <= send_idx + 3'h1;
      end
   end
   assign crc_bus.clear = crc_clear || bus_reset;
   // Both directions feed the engine so command, address and data all count
   assign crc_bus.shift = !crc_send && ((rx_valid) ||
      (tx_mode && state == swc_pkg::SWC_IDLE && fall));
   assign crc_bus.bit_in = rx_valid ? rx_bit : tx_bit;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         crc_value <= 8'h00;
      end else begin
         crc_value <= crc_bus.crc;
      end
   end
   assign dq_out = 1'b0;
   assign dq_oe = drive_zero; // Open drain, low only

   // ************************************
   // Checks
   // ************************************
   // Length of the current pull, since long holds exceed any repetition count
   logic [swc_pkg::CNT_W-1:0] oe_len;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         oe_len <= '0;
      end else if (!dq_oe) begin
         oe_len <= '0;
      end else begin
         oe_len <= oe_len + 1'b1;
      end
   end

   a_presence_len: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(state == swc_pkg::SWC_PRES) |-> dq_oe [*8])
      else $error("presence pulse too short");
   a_presence_wait: assert property (@(posedge clk) disable iff (!rst_n)
      bus_reset |-> !dq_oe [*8])
      else $error("presence started too early");
   a_read_zero_held: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(dq_oe) && state == swc_pkg::SWC_SLOT |-> dq_oe [*8])
      else $error("read zero released early");
   a_read_one_quiet: assert property (@(posedge clk) disable iff (!rst_n)
      state == swc_pkg::SWC_IDLE && fall && tx_mode && cur_tx |=> !dq_oe [*8])
      else $error("read one drove line");
   a_long_low_reset: assert property (@(posedge clk) disable iff (!rst_n)
      low_cnt == swc_pkg::CNT_W'(swc_pkg::RESET_DETECT_CYC) |->
      ##[0:2] (state == swc_pkg::SWC_LOW || state == swc_pkg::SWC_PWAIT))
      else $error("long low not taken as reset");
   a_crc_reset_clr: assert property (@(posedge clk) disable iff (!rst_n)
      bus_reset |=> ##1 crc_value == 8'h00)
      else $error("crc not cleared on reset");
   a_presence_span: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(dq_oe) && $past(state) == swc_pkg::SWC_PRES |->
      oe_len == swc_pkg::CNT_W'(swc_pkg::PRESENCE_PULSE_CYC))
      else $error("presence pulse length wrong");
   a_read_zero_span: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(dq_oe) && $past(state) == swc_pkg::SWC_SLOT |->
      oe_len > swc_pkg::CNT_W'(swc_pkg::READ_HOLD_CYC))
      else $error("read zero hold too short");
   a_reset_presence: assert property (@(posedge clk) disable iff (!rst_n)
      bus_reset |-> state == swc_pkg::SWC_PWAIT)
      else $error("reset end did not start presence wait");
   c_presence: cover property (@(posedge clk) state == swc_pkg::SWC_PRES);
   c_rx_bit: cover property (@(posedge clk) rx_valid);
   c_read_zero: cover property (@(posedge clk) state == swc_pkg::SWC_SLOT && dq_oe);
   c_bus_reset: cover property (@(posedge clk) bus_reset);
   c_read_one: cover property (@(posedge clk) state == swc_pkg::SWC_IDLE && fall && tx_mode && cur_tx);
endmodule // swc_slave

//--- testbench/swc_master_model.sv
// Bus master model driving the shared single-wire line
`timescale 1ns/1ns
module swc_master_model (
   input wire logic clk,
   input wire logic dq,
   output logic pull_low
);
   // ***************
   // Slot generation
   // ***************
   initial pull_low = 1'b0;
   // Reset low 480 us (< 960 us), then 480 us high before anything else
   task automatic reset_seq(output logic early, output logic mid, output logic late);
      pull_low <= 1'b1;
      repeat (4800) @(posedge clk);
      pull_low <= 1'b0;
      repeat (150) @(posedge clk);
      #1 early = dq;
      repeat (450) @(posedge clk);
      #1 mid = dq;
      repeat (2400) @(posedge clk);
      #1 late = dq;
      repeat (1800) @(posedge clk);
   endtask
   // Slot 62 us: one low 5 us, zero low 60 us, recovery after
   task automatic write_bit(input logic b);
      pull_low <= 1'b1;
      repeat (b ? 50 : 600) @(posedge clk);
      pull_low <= 1'b0;
      repeat (b ? 570 : 20) @(posedge clk);
   endtask
   // Programming level reads as a high line; idle high again after 480 us
   task automatic program_pulse(output logic idle);
      pull_low <= 1'b0;
      repeat (4800) @(posedge clk);
      #1 idle = dq;
      repeat (50) @(posedge clk);
   endtask
   // Line looked at 1 us and 15 us after our fall
   task automatic read_bit(output logic v, output logic held);
      pull_low <= 1'b1;
      repeat (10) @(posedge clk);
      pull_low <= 1'b0;
      #1 v = dq;
      repeat (140) @(posedge clk);
      #1 held = (dq === v);
      repeat (470) @(posedge clk);
   endtask
endmodule // swc_master_model

//--- testbench/swc_slave_tb_top.sv
// Testbench top for the single-wire slave
`timescale 1ns/1ns
module swc_slave_tb_top;
   // *****
   // Setup
   // *****
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic tx_bit = 1'b0;
   logic tx_mode = 1'b0;
   logic crc_clear = 1'b0;
   logic crc_send = 1'b0;
   logic dq_out, dq_oe, rx_bit, rx_valid, bus_reset, m_low;
   logic [7:0] crc_value;
   logic [7:0] rx_sh = 8'h00;
   int num_errors = 0;
   int tests_run = 0;
   int n_rst = 0;
   // Open drain with pull-up: idle high unless someone pulls
   wire dq = (dq_oe ? dq_out : 1'b1) & !m_low;
   initial forever #50 clk = !clk;
   swc_slave i_swc_slave (.clk(clk), .rst_n(rst_n), .dq_in(dq), .dq_out(dq_out),
      .dq_oe(dq_oe), .tx_bit(tx_bit), .tx_mode(tx_mode), .crc_clear(crc_clear),
      .crc_send(crc_send), .rx_bit(rx_bit), .rx_valid(rx_valid),
      .bus_reset(bus_reset), .crc_value(crc_value));
   swc_master_model i_swc_master_model (.clk(clk), .dq(dq), .pull_low(m_low));
   always @(posedge clk) begin
      if (rx_valid === 1'b1) rx_sh <= {rx_bit, rx_sh[7:1]};
      if (bus_reset === 1'b1) n_rst <= n_rst + 1;
   end
   // Own reference, reflected x^8+x^5+x^4+1, LSB first from zero
   function automatic logic [7:0] crc_ref(input logic [7:0] c, input logic [7:0] d);
      for (int i = 0; i < 8; i++) begin
         c = (c >> 1) ^ ((c[0] ^ d[i]) ? 8'h8c : 8'h00);
      end
      return c;
   endfunction
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic send_byte(input logic [7:0] b);
      for (int i = 0; i < 8; i++) i_swc_master_model.write_bit(b[i]);
   endtask
   task automatic get_byte(input logic [7:0] pat, output logic [7:0] got);
      logic v, h;
      for (int i = 0; i < 8; i++) begin
         tx_bit <= pat[i];
         @(posedge clk);
         i_swc_master_model.read_bit(v, h);
         got[i] = v;
         check("read hold", 8'h01, {7'h00, h});
      end
   endtask
   task automatic clear_crc();
      crc_clear <= 1'b1;
      @(posedge clk);
      crc_clear <= 1'b0;
      @(posedge clk);
   endtask
   // *****
   // Tests
   // *****
   task automatic t_reset();
      logic e, m, l;
      int base;
      base = n_rst;
      i_swc_master_model.reset_seq(e, m, l);
      check("presence wait", 8'h01, {7'h00, e});
      check("presence low", 8'h00, {7'h00, m});
      check("presence end", 8'h01, {7'h00, l});
      check("reset count", 8'h01, 8'(n_rst - base));
      check("crc after reset", 8'h00, crc_value);
      $display("test reset done");
   endtask
   task automatic t_write();
      clear_crc();
      send_byte(8'h33);
      check("received byte", 8'h33, rx_sh);
      check("write crc", crc_ref(8'h00, 8'h33), crc_value);
      $display("test write done");
   endtask
   task automatic t_read();
      logic [7:0] got;
      clear_crc();
      tx_mode <= 1'b1;
      get_byte(8'ha5, got);
      check("sent byte", 8'ha5, got);
      check("page crc", crc_ref(8'h00, 8'ha5), crc_value);
      tx_mode <= 1'b0;
      $display("test read done");
   endtask
   task automatic t_crc_round();
      logic [7:0] exp, got;
      logic q;
      int base;
      clear_crc();
      send_byte(8'hf0);
      send_byte(8'h00);
      exp = crc_ref(crc_ref(8'h00, 8'hf0), 8'h00);
      check("cmd crc", exp, crc_value);
      tx_mode <= 1'b1;
      crc_send <= 1'b1;
      get_byte(8'h00, got);
      check("returned crc", exp, got);
      tx_mode <= 1'b0;
      crc_send <= 1'b0;
      // Program only once the returned CRC agrees with our own
      q = 1'b1;
      base = n_rst;
      if (got === exp) i_swc_master_model.program_pulse(q);
      check("line after program", 8'h01, {7'h00, q});
      check("reset in program", 8'(base), 8'(n_rst));
      send_byte(exp);
      check("crc residue", 8'h00, crc_value);
      // A disagreeing CRC byte must not stop reception
      send_byte(exp ^ 8'h01);
      check("byte after bad crc", exp ^ 8'h01, rx_sh);
      check("crc after bad crc", crc_ref(8'h00, exp ^ 8'h01), crc_value);
      $display("test crc round done");
   endtask
   task automatic complete_run();
      $display("checks %0d errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      // Tests take about 5.9 ms; margin on top
      #7000000;
      num_errors++;
      complete_run();
   end
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge clk);
      t_reset();
      t_write();
      t_read();
      t_crc_round();
      t_reset();
      complete_run();
   end
endmodule // swc_slave_tb_top
